// ### src/swdrv_pkg.sv
// package: register map, field layout and timing for the switch driver
package swdrv_pkg;
  localparam int unsigned WORD_W   = 6;
  localparam int unsigned CLK_MHZ  = 125;
  localparam int unsigned LATCH_MS = 200;
  localparam int unsigned LATCH_CYC = LATCH_MS * 1000 * CLK_MHZ;
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_PAR    = 12'h004;
  localparam logic [11:0] OFF_OUT    = 12'h008;
  localparam logic [11:0] OFF_STAT   = 12'h00c;
  localparam logic [11:0] OFF_SHREG  = 12'h010;
  localparam int unsigned CTRL_LE  = 0;
  localparam int unsigned CTRL_PS  = 1;
  localparam int unsigned CTRL_PLO = 2;
  localparam int unsigned CTRL_PHI = 3;
  localparam logic [3:0]  CTRL_RST = 4'h2;
  localparam logic [5:0]  PUP_NONE = 6'h00;
  localparam logic [5:0]  PUP_B4   = 6'h10;
  localparam logic [5:0]  PUP_B5   = 6'h20;
  localparam logic [5:0]  PUP_ALL  = 6'h3f;

  typedef enum logic [1:0] {SWDRV_WAIT, SWDRV_RUN} swdrv_phase_t;

  typedef struct packed {
    logic powerup_sel_hi;
    logic powerup_sel_lo;
    logic port_sel;
    logic load_strobe;
  } swdrv_ctrl_t;

  typedef struct packed {
    swdrv_phase_t phase;
    logic [31:0]  wait_cnt;
    swdrv_ctrl_t  ctrl;
    logic [5:0]   parallel_inputs;
    logic [5:0]   true_outputs;
    logic [1:0]   tgl_sync;
    logic         tgl_seen;
    logic [5:0]   word_snap;
    logic [31:0]  prdata;
  } swdrv_state_t;

  typedef struct packed {
    logic [5:0] word;
    logic       shift_out;
  } swdrv_link_t;
endpackage : swdrv_pkg

// ### src/swdrv_shift.sv
// serial shift chain clocked by the link clock
`timescale 1ns/1ps
module swdrv_shift
  import swdrv_pkg::*;
(
  // link side
  input  wire logic        sclk,
  input  wire logic        presetn,
  input  wire logic        shift_in,
  input  wire logic        load_strobe,
  input  wire logic        port_sel,
  // to core
  output swdrv_link_t      link,
  output logic             word_tgl
);
  typedef struct packed {
    logic [5:0] sreg;
    logic [5:0] dly;
    logic [1:0] le_s;
    logic [1:0] ps_s;
    logic       tgl;
  } swdrv_sh_state_t;

  swdrv_sh_state_t st_r;
  swdrv_sh_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.le_s = {st_r.le_s[0], load_strobe};
    st_nxt.ps_s = {st_r.ps_s[0], port_sel};
    // masked while strobe high, so the word cannot move during a load
    if (st_r.ps_s[1] && !st_r.le_s[1]) begin
      st_nxt.sreg = {st_r.sreg[4:0], shift_in};
      st_nxt.tgl  = ~st_r.tgl;
    end
    // pass-through runs on every edge, independent of mode
    st_nxt.dly = {st_r.dly[4:0], shift_in};
  end

  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.word      = st_r.sreg;
  assign link.shift_out = st_r.dly[5];
  assign word_tgl       = st_r.tgl;

  property p_passthru;
    @(posedge sclk) disable iff (!presetn)
      1 ##6 1 |-> st_r.dly[5] == $past(shift_in, 6);
  endproperty
  a_passthru: assert property (p_passthru)
    else $error("pass-through not six clocks late");

  property p_msb_first;
    @(posedge sclk) disable iff (!presetn)
      (st_r.ps_s[1] && !st_r.le_s[1]) |=> st_r.sreg[0] == $past(shift_in);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("serial bit not captured on rising edge");

  property p_masked;
    @(posedge sclk) disable iff (!presetn)
      st_r.le_s[1] |=> $stable(st_r.sreg);
  endproperty
  a_masked: assert property (p_masked)
    else $error("shift register moved while strobe high");
endmodule : swdrv_shift

// ### src/swdrv_top.sv
// switch driver core: apb registers, power-up select, output latch
// Function
// - strobe low at power-up: use select inputs
// - strobe high at power-up: use parallel inputs
// - latch power-up state after 200 ms
// - bit 0: true low, complement high
// - selects 00/01/10/11 give none/b4/b5/all
// - pass-through output six clocks late
// - serial word msb first, rising edge
// - strobe high loads outputs, masks clock
// - port-select low loads from parallel inputs
// - outputs hold while strobe stays low
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module swdrv_top
  import swdrv_pkg::*;
#(
  parameter int unsigned LATCH_CYCLES = LATCH_CYC
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  input  wire logic        sclk,
  input  wire logic        shift_in,
  output logic             shift_out,
  // switch outputs
  output logic      [5:0]  true_outputs,
  output logic      [5:0]  complement_outputs,
  output logic             powerup_done
);
  swdrv_state_t st_r;
  swdrv_state_t st_nxt;
  swdrv_link_t  link;
  logic         word_tgl;
  logic         wr_en;
  logic         rd_en;
  logic         mapped;
  logic [5:0]   src_word;

  function automatic logic [5:0] pup_word(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00:   pup_word = PUP_NONE;
      2'b01:   pup_word = PUP_B4;
      2'b10:   pup_word = PUP_B5;
      default: pup_word = PUP_ALL;
    endcase
  endfunction : pup_word

  swdrv_shift u_shift (
    .sclk        (sclk),
    .presetn     (presetn),
    .shift_in    (shift_in),
    .load_strobe (st_r.ctrl.load_strobe),
    .port_sel    (st_r.ctrl.port_sel),
    .link        (link),
    .word_tgl    (word_tgl)
  );

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  assign mapped = paddr == OFF_CTRL || paddr == OFF_PAR ||
                  paddr == OFF_OUT || paddr == OFF_STAT ||
                  paddr == OFF_SHREG;
  // parallel mode takes the word from parallel_inputs, not the serial chain; the pass-through still runs
  assign src_word = st_r.ctrl.port_sel ? st_r.word_snap
                                       : st_r.parallel_inputs;

  always_comb begin
    st_nxt = st_r;
    // toggle crossing: word is stable after toggle is seen twice
    st_nxt.tgl_sync = {st_r.tgl_sync[0], word_tgl};
    st_nxt.tgl_seen = st_r.tgl_sync[1];
    if (st_r.tgl_sync[1] != st_r.tgl_seen) begin
      st_nxt.word_snap = link.word;
    end
    if (wr_en && paddr == OFF_CTRL) begin
      st_nxt.ctrl = swdrv_ctrl_t'(pwdata[3:0]);
    end
    if (wr_en && paddr == OFF_PAR) begin
      st_nxt.parallel_inputs = pwdata[5:0];
    end
    case (st_r.phase)
      SWDRV_WAIT: begin
        if (st_r.wait_cnt >= LATCH_CYCLES - 1) begin
          st_nxt.phase = SWDRV_RUN;
          if (st_r.ctrl.load_strobe) begin
            st_nxt.true_outputs = st_r.parallel_inputs;
          end else begin
            st_nxt.true_outputs = pup_word(st_r.ctrl.powerup_sel_hi,
                                           st_r.ctrl.powerup_sel_lo);
          end
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt + 32'h1;
        end
      end
      SWDRV_RUN: begin
        // strobe low freezes outputs in every mode
        if (st_r.ctrl.load_strobe) begin
          st_nxt.true_outputs = src_word;
        end
      end
      default: st_nxt.phase = SWDRV_WAIT;
    endcase
    if (rd_en) begin
      case (paddr)
        OFF_CTRL:  st_nxt.prdata = {28'h0, st_r.ctrl};
        OFF_PAR:   st_nxt.prdata = {26'h0, st_r.parallel_inputs};
        OFF_OUT:   st_nxt.prdata = {26'h0, st_r.true_outputs};
        OFF_STAT:  st_nxt.prdata = {31'h0, st_r.phase == SWDRV_RUN};
        OFF_SHREG: st_nxt.prdata = {26'h0, st_r.word_snap};
        default:   st_nxt.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= '0;
      st_r.ctrl <= swdrv_ctrl_t'(CTRL_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  // no wait state: read data is prepared in setup
  assign pready             = psel && penable;
  assign pslverr            = psel && penable && !mapped;
  assign prdata             = st_r.prdata;
  assign true_outputs       = st_r.true_outputs;
  assign complement_outputs = ~st_r.true_outputs;
  assign powerup_done       = st_r.phase == SWDRV_RUN;
  assign shift_out          = link.shift_out;

  property p_hold_low;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_RUN && !st_r.ctrl.load_strobe)
        |=> $stable(st_r.true_outputs);
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("outputs moved while strobe low");

  property p_compl;
    @(posedge pclk) disable iff (!presetn)
      complement_outputs == ~true_outputs;
  endproperty
  a_compl: assert property (p_compl)
    else $error("complement output not inverted");

  property p_pup_sel;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_nxt.phase == SWDRV_RUN
       && !st_r.ctrl.load_strobe)
        |=> true_outputs == pup_word($past(st_r.ctrl.powerup_sel_hi),
                                     $past(st_r.ctrl.powerup_sel_lo));
  endproperty
  a_pup_sel: assert property (p_pup_sel)
    else $error("power-up word not from select inputs");

  property p_pup_par;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_nxt.phase == SWDRV_RUN
       && st_r.ctrl.load_strobe)
        |=> true_outputs == $past(st_r.parallel_inputs);
  endproperty
  a_pup_par: assert property (p_pup_par)
    else $error("power-up word not from parallel inputs");

  property p_latch_time;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT) |-> st_r.wait_cnt < LATCH_CYCLES;
  endproperty
  a_latch_time: assert property (p_latch_time)
    else $error("power-up latch late");

  property p_table;
    @(posedge pclk) disable iff (!presetn)
      pup_word(1'b1, 1'b1) == 6'h3f && pup_word(1'b0, 1'b1) == 6'h10;
  endproperty
  a_table: assert property (p_table)
    else $error("power-up table wrong");

  property p_par_load;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_RUN && st_r.ctrl.load_strobe
       && !st_r.ctrl.port_sel)
        |=> true_outputs == $past(st_r.parallel_inputs);
  endproperty
  a_par_load: assert property (p_par_load)
    else $error("parallel inputs not transferred");

  property p_le_load;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_RUN && st_r.ctrl.load_strobe
       && st_r.ctrl.port_sel)
        |=> true_outputs == $past(st_r.word_snap);
  endproperty
  a_le_load: assert property (p_le_load)
    else $error("serial word not transferred on strobe");

  property p_wait_dark;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT) |-> true_outputs == '0;
  endproperty
  a_wait_dark: assert property (p_wait_dark)
    else $error("outputs driven before power-up latch");

  property p_done_stays;
    @(posedge pclk) disable iff (!presetn)
      powerup_done |=> powerup_done;
  endproperty
  a_done_stays: assert property (p_done_stays)
    else $error("power-up state left after latch");

  property p_cnt_step;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_r.wait_cnt < LATCH_CYCLES - 1)
        |=> st_r.phase == SWDRV_WAIT
            && st_r.wait_cnt == $past(st_r.wait_cnt) + 32'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("latch counter did not advance");

  property p_cnt_end;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_r.wait_cnt == LATCH_CYCLES - 1)
        |=> powerup_done;
  endproperty
  a_cnt_end: assert property (p_cnt_end)
    else $error("power-up latch not taken at end of delay");

  property p_sel_none;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_nxt.phase == SWDRV_RUN
       && !st_r.ctrl.load_strobe && !st_r.ctrl.powerup_sel_hi
       && !st_r.ctrl.powerup_sel_lo)
        |=> true_outputs == PUP_NONE;
  endproperty
  a_sel_none: assert property (p_sel_none)
    else $error("select 00 did not give all zero");

  property p_sel_b4;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_nxt.phase == SWDRV_RUN
       && !st_r.ctrl.load_strobe && !st_r.ctrl.powerup_sel_hi
       && st_r.ctrl.powerup_sel_lo)
        |=> true_outputs == PUP_B4;
  endproperty
  a_sel_b4: assert property (p_sel_b4)
    else $error("select 01 did not give bit 4 only");

  property p_sel_b5;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_nxt.phase == SWDRV_RUN
       && !st_r.ctrl.load_strobe && st_r.ctrl.powerup_sel_hi
       && !st_r.ctrl.powerup_sel_lo)
        |=> true_outputs == PUP_B5;
  endproperty
  a_sel_b5: assert property (p_sel_b5)
    else $error("select 10 did not give bit 5 only");

  property p_sel_all;
    @(posedge pclk) disable iff (!presetn)
      (st_r.phase == SWDRV_WAIT && st_nxt.phase == SWDRV_RUN
       && !st_r.ctrl.load_strobe && st_r.ctrl.powerup_sel_hi
       && st_r.ctrl.powerup_sel_lo)
        |=> true_outputs == PUP_ALL;
  endproperty
  a_sel_all: assert property (p_sel_all)
    else $error("select 11 did not give all ones");

  property p_wr_ctrl;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && paddr == OFF_CTRL)
        |=> st_r.ctrl == swdrv_ctrl_t'($past(pwdata[3:0]));
  endproperty
  a_wr_ctrl: assert property (p_wr_ctrl)
    else $error("control write not taken");

  property p_wr_par;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && paddr == OFF_PAR)
        |=> st_r.parallel_inputs == $past(pwdata[5:0]);
  endproperty
  a_wr_par: assert property (p_wr_par)
    else $error("parallel input write not taken");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !mapped)
        |-> pslverr ##1 ($stable(st_r.ctrl)
                         && $stable(st_r.parallel_inputs));
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_rd_out;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == OFF_OUT)
        |=> prdata == {26'h0, $past(true_outputs)};
  endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("output read-back wrong");

  property p_rd_stat;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == OFF_STAT)
        |=> prdata == {31'h0, $past(powerup_done)};
  endproperty
  a_rd_stat: assert property (p_rd_stat)
    else $error("status read-back wrong");

  property p_rd_word;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == OFF_SHREG)
        |=> prdata == {26'h0, $past(st_r.word_snap)};
  endproperty
  a_rd_word: assert property (p_rd_word)
    else $error("serial word read-back wrong");

  property p_snap;
    @(posedge pclk) disable iff (!presetn)
      (st_r.tgl_sync[1] != st_r.tgl_seen)
        |=> st_r.word_snap == $past(link.word);
  endproperty
  a_snap: assert property (p_snap)
    else $error("serial word not captured after toggle");

  property p_snap_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_r.tgl_sync[1] == st_r.tgl_seen)
        |=> $stable(st_r.word_snap);
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("serial word copy moved without toggle");

  property p_par_src;
    @(posedge pclk) disable iff (!presetn)
      !st_r.ctrl.port_sel |-> src_word == st_r.parallel_inputs;
  endproperty
  a_par_src: assert property (p_par_src)
    else $error("parallel mode not using parallel inputs");
endmodule : swdrv_top

// ### bench/swdrv_host.sv
// host model driving the serial link of the switch driver
`timescale 1ns/1ps
module swdrv_host (
  // serial link
  output logic      sclk,
  output logic      shift_in,
  input  wire logic shift_out
);
  // clock stands still outside frames
  initial begin
    sclk     = 1'b0;
    shift_in = 1'b0;
  end

  // one 48 ns clock, off the pclk grid
  task automatic pulse();
    #20 sclk = 1'b1;
    #24 sclk = 1'b0;
    #4;
  endtask : pulse

  // word goes out msb first, data set while clock is low
  task automatic send(input logic [11:0] b, output logic [11:0] so);
    for (int i = 11; i >= 0; i--) begin
      shift_in = b[i];
      // taken as a chained device would: just before the rising edge
      #20 so[i] = shift_out;
      sclk = 1'b1;
      #24 sclk = 1'b0;
      #4;
    end
    // released line shows the inverse, not the last bit
    shift_in = ~b[0];
  endtask : send
endmodule : swdrv_host

// ### bench/swdrv_top_tb.sv
// self-checking bench for the switch driver core
`timescale 1ns/1ps
module swdrv_top_tb;
  import swdrv_pkg::*;
  localparam int unsigned LAT = 20;
  localparam logic [5:0] PUP_TAB [4] = '{PUP_NONE, PUP_B4, PUP_B5, PUP_ALL};

  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk, shift_in, shift_out, powerup_done;
  logic [5:0]  true_outputs, complement_outputs, p, w, pre;
  logic [11:0] so;
  logic [32:0] exp_q [$];
  int          n_mismatch, n_checks, seed, t;

  swdrv_top #(.LATCH_CYCLES(LAT)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .shift_in(shift_in), .shift_out(shift_out),
    .true_outputs(true_outputs), .complement_outputs(complement_outputs),
    .powerup_done(powerup_done)
  );
  swdrv_host host (.sclk(sclk), .shift_in(shift_in), .shift_out(shift_out));

  always #4 pclk = ~pclk;

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic wr,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  task automatic chk_out(input logic [5:0] e);
    check({21'h0, true_outputs, complement_outputs}, {21'h0, e, ~e});
  endtask : chk_out

  // reset also gives one link clock edge; the link syncs clear on presetn alone
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    fork
      host.pulse();
    join_none
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // read results are compared in order of issue
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) check(33'h1, 33'h0);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite} = '0;
    paddr  = '0;
    pwdata = '0;
    seed   = 2;
    for (int s = 0; s < 5; s++) begin
      do_reset();
      chk_out(6'h00);
      p = 6'($random(seed));
      apb(OFF_PAR, 1'b1, {26'h0, p});
      if (s < 4) apb(OFF_CTRL, 1'b1, {28'h0, 2'(s), 2'b10});
      else apb(OFF_CTRL, 1'b1, {28'h0, p[1:0], 2'b01});
      check({32'h0, powerup_done}, 33'h0);
      t = 0;
      while (powerup_done !== 1'b1 && t < 100) begin
        @(posedge pclk);
        t++;
      end
      check(33'(t), 33'(LAT - 5));
      @(negedge pclk);
      chk_out(s < 4 ? PUP_TAB[s] : p);
      if (s < 4) begin
        // new parallel input data must not reach frozen outputs
        apb(OFF_PAR, 1'b1, {26'h0, ~p});
        repeat (4) @(posedge pclk);
        chk_out(PUP_TAB[s]);
      end
    end
    apb(OFF_CTRL, 1'b1, 32'h2);
    w   = 6'($random(seed));
    pre = 6'($random(seed));
    host.send({pre, w}, so);
    check({27'h0, so[5:0]}, {27'h0, pre});
    repeat (5) @(posedge pclk);
    rd(OFF_SHREG, {27'h0, w});
    chk_out(p);
    apb(OFF_CTRL, 1'b1, 32'h3);
    repeat (3) @(posedge pclk);
    chk_out(w);
    rd(OFF_OUT, {27'h0, w});
    rd(OFF_STAT, 33'h1);
    apb(OFF_CTRL, 1'b1, 32'h1);
    p = 6'($random(seed));
    apb(OFF_PAR, 1'b1, {26'h0, p});
    repeat (3) @(posedge pclk);
    chk_out(p);
    rd(12'h014, {1'b1, 32'h0});
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule : swdrv_top_tb
